// [core/stc_pkg.sv]
// Package: register map, field layout and timing of the 16-bit counter
package stc_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNT_LO = 3'h1;
    localparam logic [2:0] ADDR_COUNT_HI = 3'h2;
    localparam logic [2:0] ADDR_IRQ = 3'h3;
    localparam logic [2:0] ADDR_PINS = 3'h4;
    // Control register fields
    localparam int BIT_WIDE = 7;
    localparam int BIT_TB_HI = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_TB_LO = 3;
    localparam int BIT_SYNC_DIS = 2;
    localparam int BIT_CLK_SRC = 1;
    localparam int BIT_RUN = 0;
    // Interrupt register fields
    localparam int BIT_OVF_FLAG = 0;
    localparam int BIT_OVF_EN = 1;
    localparam int BIT_OSC_EN = 2;
    // Reset values and maximum count
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    // Special-event compare mode code
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
    // Instruction cycle is the system clock divided by this
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

    // Operating modes
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_SYNC_COUNTER,
        MODE_ASYNC_COUNTER
    } stc_mode_t;

    // Register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } stc_req_t;
endpackage

// [core/stc_timer.sv]
// Sixteen-bit timer/counter with prescaler, buffered access and overflow
`timescale 1ns/1ns
// Notes on behaviour
// - Wide-access bit selects 16-bit or 8-bit access
// - Time-base field picks timer per capture unit
// - Prescaler divides by 1, 2, 4 or 8
// - Sync-disable bit skips synchroniser on external clock
// - First external rising edge needs prior falling edge
// - Count instruction cycles or external rising edges
// - Run bit enables counting, else holds count
// - Source and sync bits choose among three modes
// - Oscillator enable blanks shared pins, ignores direction
// - Low-byte read copies high byte to buffer
// - Low-byte write loads high from buffer
// - No direct high-byte path in wide mode
// - Low-byte write clears prescaler; high write doesn't
// - Count wraps FFFF to 0000 and sets flag
// - Interrupt request only while enable bit set
// - Special-event compare match resets the counter
// - Write beats a coincident special-event reset
// - Unit two special event never sets flag
module stc_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire stc_pkg::stc_req_t req,
    output logic [7:0] rdata,
    // External count clock and companion oscillator
    input wire logic extClkPin,
    input wire logic oscClk,
    // Shared pins: raw levels and port direction bits
    input wire logic [1:0] sharedPinIn,
    input wire logic [1:0] sharedDirIn,
    output logic [1:0] sharedPinRead,
    output logic [1:0] sharedDir,
    // Capture/compare units
    input wire logic [3:0] unitOneMode,
    input wire logic [3:0] unitTwoMode,
    input wire logic unitOneMatch,
    input wire logic unitTwoMatch,
    // Outputs
    output logic [15:0] countOut,
    output logic unitOneUsesThis,
    output logic unitTwoUsesThis,
    output logic irqReq
);
    logic [7:0] control;
    logic [15:0] count;
    logic [7:0] hiBuffer;
    logic ovfFlag;
    logic ovfEn;
    logic oscEn;
    logic [2:0] prescale;
    logic [1:0] instrDiv;
    logic [1:0] extSync;
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic extPrev;
    logic extRawPrev;
    logic armed;
    logic tick;
    logic srcEdge;
    logic prescaleHit;
    logic specialReset;
    logic fromUnitOne;
    logic fromUnitTwo;
    logic wideMode;
    logic extRaw;
    logic extLevel;
    logic extLevelPrev;
    stc_pkg::stc_mode_t mode;

    assign wideMode = control[stc_pkg::BIT_WIDE];
    // External source: companion oscillator when enabled, else the pin
    assign extRaw = oscEn ? oscClk : extClkPin;

    // Mode decode from source and sync bits
    always_comb begin
        if (!control[stc_pkg::BIT_CLK_SRC]) begin
            mode = stc_pkg::MODE_TIMER;
        end else if (control[stc_pkg::BIT_SYNC_DIS]) begin
            mode = stc_pkg::MODE_ASYNC_COUNTER;
        end else begin
            mode = stc_pkg::MODE_SYNC_COUNTER;
        end
    end

    // Two-stage synchronisers for the external clock and pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            extSync <= 2'h0;
            pinMeta <= 2'h0;
            pinSync <= 2'h0;
        end else begin
            extSync <= {extSync[0], extRaw};
            // Only the second stage feeds the blanking mux
            pinMeta <= sharedPinIn;
            pinSync <= pinMeta;
        end
    end

    // Async mode samples the raw level once, skipping the second stage;
    // with a single clock domain it still costs one flop of latency.
    assign extLevel = (mode == stc_pkg::MODE_ASYNC_COUNTER) ? extRawPrev
                                                          : extSync[1];
    assign extLevelPrev = extPrev;

    // Instruction-cycle divider: one pulse every four system clocks
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            instrDiv <= 2'h0;
        end else begin
            instrDiv <= instrDiv + 2'h1;
        end
    end

    // Edge tracking; a falling edge arms counting of later rises
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            extPrev <= 1'b0;
            extRawPrev <= 1'b0;
            armed <= 1'b0;
        end else begin
            extRawPrev <= extRaw;
            extPrev <= extLevel;
            if (!control[stc_pkg::BIT_CLK_SRC]) begin
                armed <= 1'b0;
            end else if (extLevelPrev && !extLevel) begin
                armed <= 1'b1;
            end
        end
    end

    // Source pulse: instruction cycle or armed external rise
    always_comb begin
        if (!control[stc_pkg::BIT_CLK_SRC]) begin
            srcEdge = (instrDiv == stc_pkg::INSTR_LAST);
        end else begin
            srcEdge = armed && extLevel && !extLevelPrev;
        end
    end

    // Prescale hit at the selected power of two
    always_comb begin
        case (control[stc_pkg::BIT_PS_HI:stc_pkg::BIT_PS_LO])
            2'b00: prescaleHit = 1'b1;
            2'b01: prescaleHit = prescale[0];
            2'b10: prescaleHit = &prescale[1:0];
            2'b11: prescaleHit = &prescale;
            default: prescaleHit = 1'b1;
        endcase
    end
    assign tick = srcEdge && control[stc_pkg::BIT_RUN] && prescaleHit;

    // Prescaler; only a low-byte write clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 3'h0;
        end else if (req.wr && req.addr == stc_pkg::ADDR_COUNT_LO) begin
            prescale <= 3'h0;
        end else if (srcEdge && control[stc_pkg::BIT_RUN]) begin
            prescale <= prescale + 3'h1;
        end
    end

    // Time-base ownership of the two capture units
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unitOneUsesThis <= 1'b0;
            unitTwoUsesThis <= 1'b0;
        end else begin
            unitOneUsesThis <= control[stc_pkg::BIT_TB_HI];
            unitTwoUsesThis <= control[stc_pkg::BIT_TB_HI]
                             | control[stc_pkg::BIT_TB_LO];
        end
    end

    // Special-event reset, not dependable in async mode
    assign fromUnitOne = unitOneUsesThis && unitOneMatch
                       && unitOneMode == stc_pkg::MODE_SPECIAL_EVENT;
    assign fromUnitTwo = unitTwoUsesThis && unitTwoMatch
                       && unitTwoMode == stc_pkg::MODE_SPECIAL_EVENT;
    assign specialReset = fromUnitOne || fromUnitTwo;

    // Control register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            control <= stc_pkg::CONTROL_RESET;
        end else if (req.wr && req.addr == stc_pkg::ADDR_CONTROL) begin
            control <= req.wdata;
        end
    end

    // Counter: software write first, then special reset, then count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= stc_pkg::COUNT_RESET;
        end else if (req.wr && req.addr == stc_pkg::ADDR_COUNT_LO) begin
            count[7:0] <= req.wdata;
            if (wideMode) begin
                count[15:8] <= hiBuffer;
            end
        end else if (req.wr && req.addr == stc_pkg::ADDR_COUNT_HI) begin
            if (!wideMode) begin
                count[15:8] <= req.wdata;
            end
        end else if (specialReset) begin
            count <= stc_pkg::COUNT_RESET;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // High-byte buffer: loaded by high writes or low reads
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hiBuffer <= 8'h00;
        end else if (wideMode && req.wr && req.addr == stc_pkg::ADDR_COUNT_HI)
        begin
            hiBuffer <= req.wdata;
        end else if (wideMode && req.rd && req.addr == stc_pkg::ADDR_COUNT_LO)
        begin
            hiBuffer <= count[15:8];
        end
    end

    // Interrupt enable and companion oscillator enable bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovfEn <= 1'b0;
            oscEn <= 1'b0;
        end else if (req.wr && req.addr == stc_pkg::ADDR_IRQ) begin
            ovfEn <= req.wdata[stc_pkg::BIT_OVF_EN];
            oscEn <= req.wdata[stc_pkg::BIT_OSC_EN];
        end
    end

    // Overflow flag: wrap sets it, set wins over a software clear;
    // a special reset pre-empts the tick so it never sets it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovfFlag <= 1'b0;
        end else if (tick && !specialReset && count == stc_pkg::COUNT_MAX
                     && !(req.wr && (req.addr == stc_pkg::ADDR_COUNT_LO
                     || req.addr == stc_pkg::ADDR_COUNT_HI))) begin
            ovfFlag <= 1'b1;
        end else if (req.wr && req.addr == stc_pkg::ADDR_IRQ) begin
            ovfFlag <= req.wdata[stc_pkg::BIT_OVF_FLAG];
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                stc_pkg::ADDR_CONTROL: rdata <= control;
                stc_pkg::ADDR_COUNT_LO: rdata <= count[7:0];
                stc_pkg::ADDR_COUNT_HI:
                    rdata <= wideMode ? hiBuffer : count[15:8];
                stc_pkg::ADDR_IRQ:
                    rdata <= {5'h00, oscEn, ovfEn, ovfFlag};
                stc_pkg::ADDR_PINS: rdata <= {6'h00, sharedPinRead};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Interrupt, count mirror and shared-pin gating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqReq <= 1'b0;
            countOut <= 16'h0000;
            sharedPinRead <= 2'h0;
            sharedDir <= 2'h0;
        end else begin
            irqReq <= ovfFlag && ovfEn;
            countOut <= count;
            sharedPinRead <= oscEn ? 2'h0 : pinSync;
            sharedDir <= oscEn ? 2'h0 : sharedDirIn;
        end
    end

    // Checks on the guarded logic
    wrap_sets_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick && !specialReset && count == 16'hFFFF && !req.wr
        |=> ovfFlag && count == 16'h0000)
        else $error("wrap did not set overflow flag");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 irqReq == $past(ovfFlag && ovfEn))
        else $error("interrupt request not gated by enable");
    run_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !control[0] && !req.wr && !specialReset |=> $stable(count))
        else $error("count moved while stopped");
    lo_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req.wr && req.addr == 3'h1 |=> count[7:0] == $past(req.wdata)
        && prescale == 3'h0)
        else $error("low write lost or prescaler kept");
    wide_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req.wr && req.addr == 3'h1 && wideMode
        |=> count[15:8] == $past(hiBuffer))
        else $error("buffer not copied to high byte");
    buffer_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req.rd && req.addr == 3'h1 && wideMode
        |=> hiBuffer == $past(count[15:8]))
        else $error("low read did not fill buffer");
    hi_direct_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req.wr && req.addr == 3'h2 |=> count[15:8] == (wideMode ?
        $past(count[15:8]) : $past(req.wdata)))
        else $error("high write took the wrong path");
    special_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        specialReset && !req.wr |=> count == 16'h0000)
        else $error("special event did not reset count");
    pin_blank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        oscEn |=> sharedPinRead == 2'h0)
        else $error("shared pins not blanked");
    unarmed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        control[1] && !armed && !req.wr && !specialReset
        |=> $stable(count))
        else $error("counted before first falling edge");
endmodule

// [verification/stc_ext_source.sv]
// External count source model: pin clock or companion oscillator
`timescale 1ns/1ns
module stc_ext_source (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Burst request: rising edges, source, half-period length
    input wire logic start,
    input wire logic [7:0] edges,
    input wire logic useOsc,
    input wire logic [1:0] halfLen,
    // Count clocks and status
    output logic pinClk,
    output logic oscClk,
    output logic busy
);
    logic [7:0] left;
    logic [1:0] phase;
    logic level;
    // Unselected source stands still low; nothing runs between bursts
    assign pinClk = level & ~useOsc;
    assign oscClk = level & useOsc;
    assign busy = (left != 8'h00) | level;
    // Stepped by the system clock, never feeds it, so unsync mode is safe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
            left <= 8'h00;
            phase <= 2'h0;
        end else if (start && !busy) begin
            left <= edges;
            phase <= 2'h0;
        end else if (busy) begin
            // Each level lasts halfLen+1 cycles, one at least
            if (phase == halfLen) begin
                phase <= 2'h0;
                level <= ~level;
                left <= level ? left : left - 8'h01;
            end else begin
                phase <= phase + 2'h1;
            end
        end
    end
endmodule

// [verification/test_sixteen_bit_timer_counter.sv]
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ns
module test_sixteen_bit_timer_counter;
    localparam logic [2:0] CTL = stc_pkg::ADDR_CONTROL;
    localparam logic [2:0] LO = stc_pkg::ADDR_COUNT_LO;
    localparam logic [2:0] HI = stc_pkg::ADDR_COUNT_HI;
    localparam logic [2:0] IRQ = stc_pkg::ADDR_IRQ;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    stc_pkg::stc_req_t req = '0;
    logic [7:0] rdata;
    logic extClkPin, oscClk, srcBusy, rdLate = 1'b0;
    logic unitOneMatch = 1'b0, unitTwoMatch = 1'b0;
    logic [1:0] sharedPinIn = 2'h0, sharedDirIn = 2'h0;
    logic [1:0] sharedPinRead, sharedDir;
    logic [3:0] unitOneMode = 4'h0, unitTwoMode = 4'h0;
    logic [15:0] countOut;
    logic unitOneUsesThis, unitTwoUsesThis, irqReq;
    logic srcStart = 1'b0, useOsc = 1'b0;
    logic [7:0] srcEdges = 8'h00;
    logic [7:0] expQ[$];
    int err_count = 0, check_count = 0, cycles = 0;
    logic [15:0] seed = 16'hB986;
    // Free-running 100 MHz clock
    always #5 clk_sys = ~clk_sys;
    stc_timer uut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
        .rdata(rdata), .extClkPin(extClkPin), .oscClk(oscClk),
        .sharedPinIn(sharedPinIn), .sharedDirIn(sharedDirIn),
        .sharedPinRead(sharedPinRead), .sharedDir(sharedDir),
        .unitOneMode(unitOneMode), .unitTwoMode(unitTwoMode),
        .unitOneMatch(unitOneMatch), .unitTwoMatch(unitTwoMatch),
        .countOut(countOut), .unitOneUsesThis(unitOneUsesThis),
        .unitTwoUsesThis(unitTwoUsesThis), .irqReq(irqReq));
    stc_ext_source src (.clk_sys(clk_sys), .rst_n(rst_n), .start(srcStart),
        .edges(srcEdges), .useOsc(useOsc), .halfLen({useOsc, 1'b1}),
        .pinClk(extClkPin), .oscClk(oscClk), .busy(srcBusy));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed[7:0];
    endfunction
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Bus tasks leave one idle cycle so a strobe is never set twice at once
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        expQ.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
    endtask
    // Cycles until countOut next changes, sampled away from the edge
    task automatic gap(output int n);
        logic [15:0] old;
        @(negedge clk_sys);
        old = countOut;
        n = 1;
        while (countOut === old && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    // Write a count byte mid-period, then time the next tick
    task automatic tick_after(input logic [2:0] a, output int n);
        gap(n);
        repeat (8) @(posedge clk_sys);
        wr(a, 8'h40);
        gap(n);
    endtask
    task automatic burst(input logic osc, input logic [7:0] k);
        useOsc <= osc;
        srcEdges <= k;
        srcStart <= 1'b1;
        @(posedge clk_sys);
        srcStart <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 300 && srcBusy; i++) @(posedge clk_sys);
        repeat (6) @(posedge clk_sys);
    endtask
    // Read data are valid only in the cycle after the strobe
    always @(posedge clk_sys) rdLate <= req.rd;
    always @(negedge clk_sys) begin
        if (rdLate && expQ.size() > 0) begin
            chk("rdata", {8'h00, expQ.pop_front()}, {8'h00, rdata});
        end
    end
    // Hang guard: whole run needs under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        int n;
        logic [7:0] a, b;
        logic [15:0] held;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(CTL, stc_pkg::CONTROL_RESET);
        rd(3'h5, 8'h00);
        for (int t = 0; t < 4; t++) begin
            wr(CTL, {1'b0, t[1], 2'b00, t[0], 3'b000});
            // Registered outputs settle after the edge; look mid-cycle
            @(negedge clk_sys);
            chk("unit one", 16'(t[1]), 16'(unitOneUsesThis));
            chk("unit two", 16'(t[1] | t[0]), 16'(unitTwoUsesThis));
            @(posedge clk_sys);
        end
        a = rnd();
        b = rnd();
        wr(HI, a);
        wr(LO, b);
        rd(LO, b);
        rd(HI, a);
        wr(HI, ~a);
        rd(HI, ~a);
        wr(CTL, 8'h80);
        wr(HI, a);
        rd(HI, a);
        rd(LO, b);
        rd(HI, ~a);
        wr(HI, 8'h5A);
        wr(LO, 8'hC3);
        rd(LO, 8'hC3);
        rd(HI, 8'h5A);
        for (int p = 0; p < 4; p++) begin
            wr(CTL, {2'b00, 2'(p), 4'h1});
            gap(n);
            gap(n);
            chk("tick gap", 16'(stc_pkg::INSTR_DIV << p), 16'(n));
        end
        tick_after(HI, n);
        chk("high write keeps prescale", 16'h1, 16'(n < 25));
        tick_after(LO, n);
        chk("low write clears prescale", 16'h1, 16'(n > 25));
        wr(CTL, 8'h30);
        @(negedge clk_sys);
        held = countOut;
        repeat (70) @(negedge clk_sys);
        chk("held count", held, countOut);
        @(posedge clk_sys);
        wr(IRQ, 8'h02);
        wr(HI, 8'hFF);
        wr(LO, 8'hFE);
        wr(CTL, 8'h01);
        repeat (16) @(posedge clk_sys);
        wr(CTL, 8'h00);
        rd(IRQ, 8'h03);
        rd(HI, 8'h00);
        chk("request", 16'h1, 16'(irqReq));
        wr(IRQ, 8'h01);
        @(negedge clk_sys);
        chk("masked request", 16'h0, 16'(irqReq));
        @(posedge clk_sys);
        wr(IRQ, 8'h00);
        wr(LO, 8'h00);
        wr(CTL, 8'h03);
        burst(1'b0, 8'h05);
        rd(LO, 8'h04);
        wr(CTL, 8'h07);
        burst(1'b0, 8'h05);
        rd(LO, 8'h09);
        a = rnd();
        sharedPinIn <= a[1:0];
        sharedDirIn <= a[3:2];
        wr(IRQ, 8'h04);
        burst(1'b1, 8'h03);
        rd(LO, 8'h0C);
        rd(stc_pkg::ADDR_PINS, 8'h00);
        chk("pins blanked", 16'h0, {12'h0, sharedPinRead, sharedDir});
        wr(IRQ, 8'h00);
        repeat (4) @(posedge clk_sys);
        chk("pins", {12'h0, sharedPinIn, sharedDirIn},
            {12'h0, sharedPinRead, sharedDir});
        wr(CTL, 8'h40);
        wr(HI, 8'hFF);
        wr(LO, 8'hFF);
        unitOneMode <= stc_pkg::MODE_SPECIAL_EVENT;
        unitTwoMode <= stc_pkg::MODE_SPECIAL_EVENT;
        unitTwoMatch <= 1'b1;
        @(posedge clk_sys);
        unitTwoMatch <= 1'b0;
        @(posedge clk_sys);
        rd(LO, 8'h00);
        rd(IRQ, 8'h00);
        wr(HI, 8'h12);
        req <= '{addr: LO, wdata: 8'h77, wr: 1'b1, rd: 1'b0};
        unitOneMatch <= 1'b1;
        @(posedge clk_sys);
        req <= '0;
        unitOneMatch <= 1'b0;
        @(posedge clk_sys);
        rd(LO, 8'h77);
        rd(HI, 8'h12);
        report_and_stop();
    end
endmodule
